//--- design/tol_local_lock.sv
// Local temperature byte pair with the high/low read coherency lock.
// Assumes conversion results and read strobes come from logic on the
// same clock, each strobe a single-cycle pulse.
`timescale 1ns/1ps
module tol_local_lock
  import tol_pkg::*;
(
  input  wire logic        clock_i,      // Device clock.
  input  wire logic        rst_b_i,      // Asynchronous reset, active low.
  input  wire logic        done_i,       // Local conversion finished.
  input  wire logic [11:0] local_reading_i, // New local temperature code.
  input  wire logic        rd_i,         // A register read takes place.
  input  wire logic        rd_hi_i,      // That read targets the high byte.
  input  wire logic        rd_lo_i,      // That read targets the low byte.
  output logic      [7:0]  hi_byte_o,    // Stored high byte.
  output logic      [7:0]  lo_byte_o     // Stored low byte, nibble at top.
);

  // ==========================================================
  // Lock state
  // ==========================================================
  tol_lock_t lock_q;
  tol_lock_t lock_d;
  wire       upd_hi;
  wire       upd_lo;

  // Next lock state from the read sequence.
  always_comb begin
    lock_d = lock_q;
    if (rd_i) begin
      case (lock_q)
        TOL_LK_OPEN: begin
          if (rd_hi_i) begin
            lock_d = TOL_LK_LOW;
          end else if (rd_lo_i) begin
            lock_d = TOL_LK_HIGH;
          end
        end
        TOL_LK_LOW: begin
          if (rd_lo_i || !rd_hi_i) begin
            lock_d = TOL_LK_OPEN;
          end
        end
        TOL_LK_HIGH: begin
          if (rd_hi_i || !rd_lo_i) begin
            lock_d = TOL_LK_OPEN;
          end
        end
        default: begin
          lock_d = TOL_LK_OPEN;
        end
      endcase
    end
  end

  // A held byte ignores the converter. The next lock state is used so
  // that a conversion landing on the locking read is held out as well.
  assign upd_hi = done_i && (lock_d != TOL_LK_HIGH);
  assign upd_lo = done_i && (lock_d != TOL_LK_LOW);

  // Lock state register.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lock_q <= TOL_LK_OPEN;
    end else begin
      lock_q <= lock_d;
    end
  end

  // Byte registers refreshed on each finished conversion unless that byte is held.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hi_byte_o <= TOL_RST_LOCAL;
      lo_byte_o <= TOL_RST_LOCAL;
    end else begin
      if (upd_hi) begin
        hi_byte_o <= local_reading_i[TOL_TEMP_W-1:TOL_FRAC_LSB];
      end
      if (upd_lo) begin
        lo_byte_o <= {local_reading_i[TOL_FRAC_LSB-1:0],
                      TOL_NIB_ZERO};
      end
    end
  end

endmodule // tol_local_lock

//--- design/tol_pkg.sv
// Package for the temperature offset and limit register bank.
// Holds register addresses, reset values, field positions and the
// coherency lock state type shared by the bank and its lock unit.
package tol_pkg;

  // ==========================================================
  // Widths and field positions
  // ==========================================================
  localparam int TOL_TEMP_W    = 12;      // Width of a full temperature code.
  localparam int TOL_FRAC_MSB  = 7;       // Top bit of a fraction nibble.
  localparam int TOL_FRAC_LSB  = 4;       // Bottom bit of a fraction nibble.
  localparam logic [3:0]  TOL_NIB_ZERO = 4'h0;   // Padding nibble.
  localparam logic [7:0]  TOL_BYTE_ZERO = 8'h00; // Unmapped read value.

  // ==========================================================
  // Register addresses
  // ==========================================================
  localparam logic [7:0] TOL_ADDR_LOCAL_HI = 8'h00; // Local temp high byte.
  localparam logic [7:0] TOL_ADDR_OFS_HI   = 8'h11; // Offset bits 11..4.
  localparam logic [7:0] TOL_ADDR_OFS_LO   = 8'h12; // Offset bits 3..0.
  localparam logic [7:0] TOL_ADDR_HI_FRAC  = 8'h13; // High limit fraction.
  localparam logic [7:0] TOL_ADDR_LO_FRAC  = 8'h14; // Low limit fraction.
  localparam logic [7:0] TOL_ADDR_LOCAL_LO = 8'h15; // Local temp low byte.
  localparam logic [7:0] TOL_ADDR_OT_LIM   = 8'h19; // Shutdown threshold.

  // ==========================================================
  // Power-on values
  // ==========================================================
  localparam logic [7:0] TOL_RST_OFS_HI   = 8'h00;
  localparam logic [7:0] TOL_RST_OFS_LO   = 8'h00;
  localparam logic [7:0] TOL_RST_HI_FRAC  = 8'h00;
  localparam logic [7:0] TOL_RST_LO_FRAC  = 8'h00;
  localparam logic [7:0] TOL_RST_LOCAL    = 8'h00;
  localparam logic [7:0] TOL_RST_OT_LIM   = 8'h6c;
  localparam logic [11:0] TOL_RST_TEMP    = 12'h000;
  localparam logic [11:0] TOL_SAT_MAX     = 12'h7ff; // Most positive code.
  localparam logic [11:0] TOL_SAT_MIN     = 12'h800; // Most negative code.

  // ==========================================================
  // Coherency lock states
  // ==========================================================
  typedef enum logic [1:0] {
    TOL_LK_OPEN = 2'b00,  // No byte is held.
    TOL_LK_LOW  = 2'b01,  // High byte was read, low byte is held.
    TOL_LK_HIGH = 2'b10   // Low byte was read, high byte is held.
  } tol_lock_t;

  // Joins a whole-degree byte with the upper nibble of a fraction byte.
  function automatic logic [11:0] tol_join(input logic [7:0] whole,
                                           input logic [7:0] frac);
    tol_join = {whole, frac[TOL_FRAC_MSB:TOL_FRAC_LSB]};
  endfunction

  // Adds two signed 12-bit codes and clamps the sum at the code range.
  function automatic logic [11:0] tol_sat_add(input logic [11:0] a,
                                              input logic [11:0] b);
    logic [12:0] s;
    s = {a[11], a} + {b[11], b};
    if (s[12] != s[11]) begin
      tol_sat_add = s[12] ? TOL_SAT_MIN : TOL_SAT_MAX;
    end else begin
      tol_sat_add = s[11:0];
    end
  endfunction

endpackage

//--- design/tol_regs.sv
// Temperature offset and limit register bank.
// Assumes a serial protocol engine on the same clock delivers register
// reads and writes as single-cycle strobes with an 8-bit address.
// The whole-degree bytes of the remote limits live in another bank and
// arrive as inputs; only their fraction bytes are stored here.
`timescale 1ns/1ps
module tol_regs
  import tol_pkg::*;
(
  input  wire logic        clock_i,          // Device clock, 100 MHz.
  input  wire logic        rst_b_i,          // Asynchronous reset, low.
  // Register access port.
  input  wire logic [7:0]  reg_addr_i,       // Register address.
  input  wire logic        reg_wr_i,         // Write strobe.
  input  wire logic [7:0]  reg_wdata_i,      // Write data.
  input  wire logic        reg_rd_i,         // Read strobe.
  output logic      [7:0]  reg_rdata_o,      // Read data, next cycle.
  // Converter side.
  input  wire logic        remote_done_i,    // Remote conversion finished.
  input  wire logic [11:0] remote_raw_i,     // Raw remote code.
  input  wire logic        local_done_i,     // Local conversion finished.
  input  wire logic [11:0] local_reading_i,  // Local code.
  // Limit high bytes kept elsewhere.
  input  wire logic [7:0]  upper_whole_i,    // High limit whole degrees.
  input  wire logic [7:0]  lower_whole_i,    // Low limit whole degrees.
  // Results.
  output logic      [11:0] remote_result_o,  // Offset-corrected result.
  output logic             remote_valid_o,   // Result updated pulse.
  output logic      [11:0] remote_upper_threshold_o, // High limit.
  output logic      [11:0] remote_lower_threshold_o, // Low limit.
  output logic      [11:0] remote_offset_value_o,    // Signed offset.
  output logic             overtemp_output_b_o       // Shutdown, low.
);

  // ==========================================================
  // Writable registers
  // ==========================================================
  logic [7:0] ofs_hi_q;
  logic [7:0] ofs_lo_q;
  logic [7:0] hi_frac_q;
  logic [7:0] lo_frac_q;
  logic [7:0] ot_lim_q;

  // Address decode for the read/write locations and the read-only local bytes.
  wire sel_ofs_hi   = (reg_addr_i == TOL_ADDR_OFS_HI);
  wire sel_ofs_lo   = (reg_addr_i == TOL_ADDR_OFS_LO);
  wire sel_hi_frac  = (reg_addr_i == TOL_ADDR_HI_FRAC);
  wire sel_lo_frac  = (reg_addr_i == TOL_ADDR_LO_FRAC);
  wire sel_ot_lim   = (reg_addr_i == TOL_ADDR_OT_LIM);
  wire sel_local_hi = (reg_addr_i == TOL_ADDR_LOCAL_HI);
  wire sel_local_lo = (reg_addr_i == TOL_ADDR_LOCAL_LO);

  // Write enables; the local byte addresses have no write path, so a
  // host write there is dropped without touching the byte pair.
  wire wr_ofs_hi    = reg_wr_i && sel_ofs_hi;
  wire wr_ofs_lo    = reg_wr_i && sel_ofs_lo;
  wire wr_hi_frac   = reg_wr_i && sel_hi_frac;
  wire wr_lo_frac   = reg_wr_i && sel_lo_frac;
  wire wr_ot_lim    = reg_wr_i && sel_ot_lim;

  // Offset high byte, whole degrees of the signed offset.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ofs_hi_q <= TOL_RST_OFS_HI;
    end else if (wr_ofs_hi) begin
      ofs_hi_q <= reg_wdata_i;
    end
  end

  // Offset low byte, fraction nibble at the top.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ofs_lo_q <= TOL_RST_OFS_LO;
    end else if (wr_ofs_lo) begin
      ofs_lo_q <= reg_wdata_i;
    end
  end

  // High limit fraction byte.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hi_frac_q <= TOL_RST_HI_FRAC;
    end else if (wr_hi_frac) begin
      hi_frac_q <= reg_wdata_i;
    end
  end

  // Low limit fraction byte.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lo_frac_q <= TOL_RST_LO_FRAC;
    end else if (wr_lo_frac) begin
      lo_frac_q <= reg_wdata_i;
    end
  end

  // Shutdown threshold, whole degrees.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ot_lim_q <= TOL_RST_OT_LIM;
    end else if (wr_ot_lim) begin
      ot_lim_q <= reg_wdata_i;
    end
  end

  // ==========================================================
  // Local temperature bytes with read coherency
  // ==========================================================
  logic [7:0] local_hi;
  logic [7:0] local_lo;

  // Every read strobe goes to the lock unit, not just reads of the two
  // local bytes: a read of any other register ends the pairing promise.
  tol_local_lock u_lock (
    .clock_i         (clock_i),
    .rst_b_i         (rst_b_i),
    .done_i          (local_done_i),
    .local_reading_i (local_reading_i),
    .rd_i            (reg_rd_i),
    .rd_hi_i         (sel_local_hi),
    .rd_lo_i         (sel_local_lo),
    .hi_byte_o       (local_hi),
    .lo_byte_o       (local_lo)
  );

  // ==========================================================
  // Read path
  // ==========================================================
  logic [7:0] rd_mux;

  // Read data select; unmapped addresses return zero. Reserved low
  // nibbles of the offset and fraction bytes are stored and read back.
  always_comb begin
    if (sel_ofs_hi) begin
      rd_mux = ofs_hi_q;
    end else if (sel_ofs_lo) begin
      rd_mux = ofs_lo_q;
    end else if (sel_hi_frac) begin
      rd_mux = hi_frac_q;
    end else if (sel_lo_frac) begin
      rd_mux = lo_frac_q;
    end else if (sel_local_lo) begin
      rd_mux = local_lo;
    end else if (sel_local_hi) begin
      rd_mux = local_hi;
    end else if (sel_ot_lim) begin
      rd_mux = ot_lim_q;
    end else begin
      rd_mux = TOL_BYTE_ZERO;
    end
  end

  // Read data register, loaded on each read strobe.
  // A read and a write to one address in one cycle return the old value.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= TOL_BYTE_ZERO;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rd_mux;
    end
  end

  // ==========================================================
  // Offset correction and limits
  // ==========================================================
  // Offset and limits formed from whole byte and fraction nibble.
  wire [11:0] ofs_full = tol_join(ofs_hi_q, ofs_lo_q);
  wire [11:0] up_full  = tol_join(upper_whole_i,
                                  hi_frac_q);
  wire [11:0] low_full = tol_join(lower_whole_i,
                                  lo_frac_q);
  // Signed sum clamps rather than wrapping past the code range, so a
  // large offset can never turn a hot reading into a cold one.
  wire [11:0] corr     = tol_sat_add(remote_raw_i,
                                     ofs_full);
  wire        ot_trip  = $signed(remote_result_o) >=
                         $signed({ot_lim_q, TOL_NIB_ZERO});

  // Joined limits and offset go out to the comparators elsewhere.
  assign remote_upper_threshold_o = up_full;
  assign remote_lower_threshold_o = low_full;
  assign remote_offset_value_o    = ofs_full;

  // Valid pulse follows each remote done strobe by one cycle.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      remote_valid_o <= 1'b0;
    end else begin
      remote_valid_o <= remote_done_i;
    end
  end

  // Corrected result, held until the next remote conversion.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      remote_result_o <= TOL_RST_TEMP;
    end else if (remote_done_i) begin
      remote_result_o <= corr;
    end
  end

  // Shutdown output, judged on the stored result, so it settles one
  // cycle after the result; no hysteresis is applied here.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      overtemp_output_b_o <= 1'b1;
    end else begin
      overtemp_output_b_o <= !ot_trip;
    end
  end

endmodule // tol_regs

//--- tb/testbench.sv
// Self-checking bench for the offset and limit register bank.
// Host model makes register cycles; the bench makes converter strobes.
`timescale 1ns/1ps
module testbench;
  // ==========================================================
  // Signals, tables and tasks
  typedef struct packed {
    logic [7:0] oh, ol; logic [11:0] raw, res; logic ot; } tol_row_t;
  logic        clock_i = 1'b0, rst_b_i = 1'b0, remote_done_i = 1'b0;
  logic        local_done_i = 1'b0, reg_wr_i, reg_rd_i, remote_valid_o;
  logic        overtemp_output_b_o;
  logic [7:0]  reg_addr_i, reg_wdata_i, reg_rdata_o, rd_v;
  logic [7:0]  upper_whole_i = 8'h55, lower_whole_i = 8'h12;
  logic [11:0] remote_raw_i = 12'h000, local_reading_i = 12'h000;
  logic [11:0] remote_result_o, remote_upper_threshold_o;
  logic [11:0] remote_lower_threshold_o, remote_offset_value_o;
  int          bad_count = 0, n_checks = 0, cyc = 0;
  tol_row_t    rows [5] = '{'{8'h00, 8'h00, 12'h100, 12'h100, 1'b1},
    '{8'hff, 8'hf0, 12'h100, 12'h0ff, 1'b1}, '{8'h7f, 8'hf0, 12'h7ff,
    12'h7ff, 1'b0}, '{8'h80, 8'h00, 12'h800, 12'h800, 1'b1},
    '{8'h01, 8'h2a, 12'h6ae, 12'h6c0, 1'b0}}; // Last lands on 0x6c0.
  logic [7:0]  ra [6] = '{8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h30};
  always #5 clock_i = ~clock_i;
  tol_regs dut_u (.clock_i, .rst_b_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i,
    .reg_rd_i, .reg_rdata_o, .remote_done_i, .remote_raw_i, .local_done_i,
    .local_reading_i, .upper_whole_i, .lower_whole_i, .remote_result_o,
    .remote_valid_o, .remote_upper_threshold_o, .remote_lower_threshold_o,
    .remote_offset_value_o, .overtemp_output_b_o);
  tol_host_model host_u (.clock_i, .rdata_i(reg_rdata_o),
    .addr_o(reg_addr_i), .wr_o(reg_wr_i), .wdata_o(reg_wdata_i),
    .rd_o(reg_rd_i));
  // Counts a comparison and reports a mismatch at once.
  task automatic chk(input string nm, input logic [11:0] e, g);
    n_checks++;
    if (g !== e) begin
      $display("FAIL %s expected %h seen %h", nm, e, g);
      bad_count++;
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    host_u.xfer(1'b1, a, d, rd_v);
  endtask
  task automatic rchk(input logic [7:0] a, e);
    host_u.xfer(1'b0, a, 8'h00, rd_v);
    chk($sformatf("reg %h", a), {4'h0, e}, {4'h0, rd_v});
  endtask
  // One conversion strobe, then waits until the shutdown output settles.
  task automatic conv(input logic loc, input logic [11:0] v);
    @(posedge clock_i);
    {remote_done_i, local_done_i, remote_raw_i, local_reading_i} <=
      {!loc, loc, v, v};
    @(posedge clock_i);
    {remote_done_i, local_done_i, remote_raw_i, local_reading_i} <=
      {2'b00, ~v, ~v};
    #1 chk("valid", {11'h0, !loc}, {11'h0, remote_valid_o});
    @(posedge clock_i);
    #1;
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Cuts a hang short well past the expected run length.
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 2000) begin
      bad_count++;
      end_of_test();
    end
  end
  initial begin
    tol_row_t r;
    repeat (3) @(posedge clock_i);
    rst_b_i <= 1'b1;
    foreach (rows[i]) begin
      r = rows[i];
      wr(8'h11, r.oh);
      wr(8'h12, r.ol);
      rchk(8'h12, r.ol);
      chk("ofs", {r.oh, r.ol[7:4]}, remote_offset_value_o);
      conv(1'b0, r.raw);
      chk("result", r.res, remote_result_o);
      chk("ot", {11'h0, r.ot}, {11'h0, overtemp_output_b_o});
    end
    $display("row table done");
    // A second reset brings back the power-on values.
    @(posedge clock_i);
    rst_b_i <= 1'b0;
    repeat (3) @(posedge clock_i);
    rst_b_i <= 1'b1;
    foreach (ra[i]) rchk(ra[i], 8'h00);
    rchk(8'h19, 8'h6c);
    wr(8'h15, 8'hff);
    rchk(8'h15, 8'h00);
    $display("reset test done");
    // Fractions joined to the whole bytes, then a lowered threshold.
    wr(8'h13, 8'ha7);
    wr(8'h14, 8'h3c);
    rchk(8'h13, 8'ha7);
    chk("upper", 12'h55a, remote_upper_threshold_o);
    chk("lower", 12'h123, remote_lower_threshold_o);
    wr(8'h19, 8'h10);
    conv(1'b0, 12'h100);
    chk("ot", 12'h000, {11'h0, overtemp_output_b_o});
    conv(1'b0, 12'h0ff);
    chk("ot", 12'h001, {11'h0, overtemp_output_b_o});
    $display("limit test done");
    // Byte pair locking: high first, low first, then a stray read.
    conv(1'b1, 12'h123);
    rchk(8'h00, 8'h12);
    conv(1'b1, 12'h456);
    rchk(8'h15, 8'h30);
    conv(1'b1, 12'h789);
    rchk(8'h15, 8'h90);
    conv(1'b1, 12'habc);
    rchk(8'h00, 8'h78);
    conv(1'b1, 12'hdef);
    rchk(8'h00, 8'hde);
    rchk(8'h11, 8'h00);
    conv(1'b1, 12'h321);
    rchk(8'h15, 8'h10);
    $display("lock test done");
    end_of_test();
  end
endmodule // testbench

//--- tb/tol_host_model.sv
// Host controller model driving the bank's register access port.
// Assumes the bank samples its strobes on the rising clock edge.
`timescale 1ns/1ps
module tol_host_model (
  input  wire logic       clock_i, // Device clock.
  input  wire logic [7:0] rdata_i, // Read data from the bank.
  output logic      [7:0] addr_o,  // Register address.
  output logic            wr_o,    // Write strobe.
  output logic      [7:0] wdata_o, // Write data.
  output logic            rd_o     // Read strobe.
);
  // ==========================================================
  // Bus cycles
  // Idle from time zero.
  initial {addr_o, wdata_o, wr_o, rd_o} = 18'h0;
  // One strobe, a write when w is set; released address and data lines show
  // their inverse so a stale address is never mistaken for a live one.
  task automatic xfer(input logic w, input logic [7:0] a, d,
                      output logic [7:0] q);
    @(posedge clock_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= w;
    rd_o <= !w;
    @(posedge clock_i);
    wr_o <= 1'b0;
    rd_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
    #1 q = rdata_i;
  endtask
endmodule // tol_host_model

//--- tb/tol_monitor.sv
// Assertion checker on the offset and limit register bank ports.
// Bound into tol_regs; it only watches and drives nothing.
`timescale 1ns/1ps
module tol_monitor (
  input wire logic        clock_i,                  // Clock.
  input wire logic        rst_b_i,                  // Reset.
  input wire logic [7:0]  reg_addr_i,               // Address.
  input wire logic        reg_wr_i,                 // Write.
  input wire logic [7:0]  reg_wdata_i,              // Data.
  input wire logic        reg_rd_i,                 // Read.
  input wire logic [7:0]  reg_rdata_o,              // Read data.
  input wire logic        remote_done_i,            // Done.
  input wire logic [11:0] remote_raw_i,             // Raw code.
  input wire logic [11:0] remote_result_o,          // Result.
  input wire logic        remote_valid_o,           // Valid.
  input wire logic [11:0] remote_upper_threshold_o, // High limit.
  input wire logic [11:0] remote_lower_threshold_o, // Low limit.
  input wire logic [11:0] remote_offset_value_o,    // Offset.
  input wire logic        overtemp_output_b_o       // Shutdown.
);
  // ==========================================================
  // Helper logic and properties
  logic [7:0]  lim_q; // Shadow of the shutdown threshold.
  logic [12:0] sum_w; // Offset sum, one bit wider to expose overflow.
  assign sum_w = {remote_raw_i[11], remote_raw_i}
               + {remote_offset_value_o[11], remote_offset_value_o};
  // Follows threshold writes so reads and compares can be judged.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) lim_q <= 8'h6c;
    else if (reg_wr_i && reg_addr_i == 8'h19) lim_q <= reg_wdata_i;
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_conv; remote_done_i ##1 remote_valid_o; endsequence
  sequence s_lone_done; remote_done_i ##1 !remote_done_i; endsequence
  a_valid_pulse: assert property (s_lone_done
    |-> remote_valid_o ##1 !remote_valid_o) else $error("valid not one pulse");
  a_result_sum: assert property (
    remote_done_i && sum_w[12] == sum_w[11]
    |=> {remote_result_o[11], remote_result_o} == $past(sum_w))
    else $error("result is not raw plus offset");
  a_offset_high: assert property (reg_wr_i && reg_addr_i == 8'h11
    |=> remote_offset_value_o[11:4] == $past(reg_wdata_i))
    else $error("offset high byte not taken");
  a_upper_frac: assert property (reg_wr_i && reg_addr_i == 8'h13
    |=> {4'h0, remote_upper_threshold_o[3:0]} == $past(reg_wdata_i) >> 4)
    else $error("high limit fraction wrong");
  a_lower_frac: assert property (reg_wr_i && reg_addr_i == 8'h14
    |=> {4'h0, remote_lower_threshold_o[3:0]} == $past(reg_wdata_i) >> 4)
    else $error("low limit fraction wrong");
  a_overtemp_cmp: assert property (s_conv
    |=> overtemp_output_b_o ==
    ($signed($past(remote_result_o)) < $signed({$past(lim_q), 4'h0})))
    else $error("shutdown output disagrees with threshold");
  a_read_limit: assert property (reg_rd_i && reg_addr_i == 8'h19
    |=> reg_rdata_o == $past(lim_q)) else $error("threshold read wrong");
  a_rdata_hold: assert property (!reg_rd_i
    |=> $stable(reg_rdata_o)) else $error("read data moved without a read");
endmodule // tol_monitor
bind tol_regs tol_monitor mon_u (.clock_i, .rst_b_i, .reg_addr_i, .reg_wr_i,
  .reg_wdata_i, .reg_rd_i, .reg_rdata_o, .remote_done_i, .remote_raw_i,
  .remote_result_o, .remote_valid_o, .remote_upper_threshold_o,
  .remote_lower_threshold_o, .remote_offset_value_o, .overtemp_output_b_o);
